// ===== inc/interval_timer_consts.vh
// Offsets, control fields and encodings of the three channel interval timer
`ifndef INTERVAL_TIMER_CONSTS_VH
`define INTERVAL_TIMER_CONSTS_VH
`define OFS_COUNTER_ZERO_DATA 2'd0
`define OFS_COUNTER_ONE_DATA 2'd1
`define OFS_COUNTER_TWO_DATA 2'd2
`define OFS_TIMER_CONTROL_WORD 2'd3
`define ADDR_WINDOW_BASE 3'h4
`define CTL_SEL_HI 7
`define CTL_SEL_LO 6
`define CTL_FMT_HI 5
`define CTL_FMT_LO 4
`define CTL_CFG_HI 3
`define CTL_CFG_LO 1
`define CTL_BCD_BIT 0
`define SEL_READBACK 2'h3
`define FMT_LATCH 2'h0
`define FMT_HIGH 2'h1
`define FMT_LOW 2'h2
`define FMT_LOW_HIGH 2'h3
`define CFG_TERMINAL 3'h0
`define CFG_ONE_SHOT 3'h1
`define CFG_RATE 3'h2
`define CFG_SQUARE 3'h3
`define CFG_SOFT_STROBE 3'h4
`define CFG_HARD_STROBE 3'h5
`define CTL_RESET_VALUE 6'h00
`define COUNT_RESET_VALUE 16'h0000
`endif

// ===== hdl/count_latch.v
// Sixteen-bit holding latch of one counter with registered read data
`timescale 1ns/100ps
`default_nettype none
module count_latch #(
  parameter WIDTH = 16
) (
  // Clock and control
  input wire clk,
  input wire ce,
  input wire rst_n,
  // Capture and release
  input wire capture,
  input wire release_latch,
  input wire [WIDTH-1:0] live_value,
  // Read side
  output reg [WIDTH-1:0] read_value,
  output reg held
);
  reg [WIDTH-1:0] hold_q;
  always @(posedge clk) begin
    if (!rst_n) begin
      hold_q <= {WIDTH{1'b0}};
      held <= 1'b0;
      read_value <= {WIDTH{1'b0}};
    end else if (ce) begin
      // A second latch command while holding keeps the first snapshot
      if (capture && !held) begin
        hold_q <= live_value;
        held <= 1'b1;
      end else if (release_latch) begin
        held <= 1'b0;
      end
      read_value <= (held && !release_latch) ? hold_q : live_value;
    end
  end
endmodule // count_latch
`default_nettype wire

// ===== hdl/interval_timer.v
// Three channel programmable interval timer with byte register window
`include "interval_timer_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module interval_timer #(
  parameter CHANNELS = 3,
  parameter WIDTH = 16
) (
  // System
  input wire CLOCK,
  input wire RST_N,
  input wire CE,
  // Byte register window
  input wire [2:0] ADDR,
  input wire WR,
  input wire RD,
  input wire [7:0] WDATA,
  output reg [7:0] RDATA,
  // Counter pins, one bit per counter, sampled as synchronous inputs
  input wire [CHANNELS-1:0] CNT_CLK,
  input wire [CHANNELS-1:0] CNT_GATE,
  output wire [CHANNELS-1:0] CNT_OUT
);
  // Decimal-aware decrement by one
  function [WIDTH-1:0] dec1;
    input [WIDTH-1:0] v;
    input bcd;
    integer k;
    reg borrow;
    begin
      dec1 = v;
      borrow = 1'b1;
      if (!bcd) begin
        dec1 = v - {{(WIDTH-1){1'b0}}, 1'b1};
      end else begin
        for (k = 0; k < 4; k = k + 1) begin
          if (borrow) begin
            if (v[k*4 +: 4] == 4'h0) begin
              dec1[k*4 +: 4] = 4'h9;
            end else begin
              dec1[k*4 +: 4] = v[k*4 +: 4] - 4'h1;
              borrow = 1'b0;
            end
          end
        end
      end
    end
  endfunction

  // Window decode, used for reads and writes
  function [2:0] port_of;
    input [2:0] a;
    begin
      port_of = {1'b0, a[1:0]};
      if (a < `ADDR_WINDOW_BASE) begin
        port_of = 3'h4;
      end
    end
  endfunction

  wire [2:0] port = port_of(ADDR);
  wire ctl_wr = WR && (port == {1'b0, `OFS_TIMER_CONTROL_WORD});
  wire [1:0] sel = WDATA[`CTL_SEL_HI:`CTL_SEL_LO];
  wire [1:0] fmt = WDATA[`CTL_FMT_HI:`CTL_FMT_LO];

  wire [WIDTH-1:0] rd_val [0:CHANNELS-1];
  wire [CHANNELS-1:0] rd_flip;
  wire [CHANNELS-1:0] rd_fmt_hi;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : chan
      reg [1:0] fmt_q;
      reg [2:0] cfg_q;
      reg bcd_q;
      reg [WIDTH-1:0] count_q;
      reg [WIDTH-1:0] preset_q;
      reg [7:0] low_byte_q;
      reg wtog_q;
      reg rtog_q;
      reg out_q;
      reg armed_q;
      reg reload_q;
      reg clk_q;
      reg gate_q;
      reg half_q;
      localparam [2:0] PORT_ID = g;
      wire sel_me = ctl_wr && (sel == PORT_ID[1:0]);
      wire is_latch = sel_me && (fmt == `FMT_LATCH);
      wire is_mode = sel_me && (fmt != `FMT_LATCH);
      wire dat_wr = WR && (port == PORT_ID);
      wire dat_rd = RD && (port == PORT_ID);
      wire [WIDTH-1:0] wval;
      wire load_done;
      wire tick = CNT_CLK[g] && !clk_q;
      wire gate_rise = CNT_GATE[g] && !gate_q;
      wire gate_ok = CNT_GATE[g];
      wire [WIDTH-1:0] nxt = dec1(count_q, bcd_q);
      wire [WIDTH-1:0] nxt2 = dec1(nxt, bcd_q);
      wire at_one = (count_q == {{(WIDTH-1){1'b0}}, 1'b1});
      wire at_two = (count_q == {{(WIDTH-2){1'b0}}, 2'b10});
      wire last_rd = (fmt_q != `FMT_LOW_HIGH) || rtog_q;
      // Load word assembled according to the transfer format
      assign wval = (fmt_q == `FMT_HIGH) ? {WDATA, 8'h00} :
                    (fmt_q == `FMT_LOW) ? {8'h00, WDATA} :
                    {WDATA, low_byte_q};
      assign load_done = dat_wr && ((fmt_q != `FMT_LOW_HIGH) || wtog_q);
      assign rd_flip[g] = rtog_q;
      assign rd_fmt_hi[g] = (fmt_q == `FMT_HIGH);
      count_latch #(.WIDTH(WIDTH)) u_latch (
        .clk(CLOCK),
        .ce(CE),
        .rst_n(RST_N),
        .capture(is_latch),
        .release_latch(dat_rd && last_rd),
        .live_value(count_q),
        .read_value(rd_val[g]),
        .held()
      );
      assign CNT_OUT[g] = out_q;
      always @(posedge CLOCK) begin
        if (!RST_N) begin
          fmt_q <= 2'h3;
          cfg_q <= 3'h0;
          bcd_q <= 1'b0;
          count_q <= `COUNT_RESET_VALUE;
          preset_q <= `COUNT_RESET_VALUE;
          low_byte_q <= 8'h00;
          wtog_q <= 1'b0;
          rtog_q <= 1'b0;
          out_q <= 1'b0;
          armed_q <= 1'b0;
          reload_q <= 1'b0;
          clk_q <= 1'b0;
          gate_q <= 1'b0;
          half_q <= 1'b0;
        end else if (CE) begin
          clk_q <= CNT_CLK[g];
          gate_q <= CNT_GATE[g];
          if (is_mode) begin
            fmt_q <= fmt;
            cfg_q <= WDATA[`CTL_CFG_HI:`CTL_CFG_LO];
            bcd_q <= WDATA[`CTL_BCD_BIT];
            wtog_q <= 1'b0;
            rtog_q <= 1'b0;
            armed_q <= 1'b0;
            reload_q <= 1'b0;
            // Config 0 starts low, the others start high
            out_q <= (WDATA[`CTL_CFG_HI:`CTL_CFG_LO] != `CFG_TERMINAL);
          end else begin
            if (dat_wr && fmt_q == `FMT_LOW_HIGH) begin
              wtog_q <= !wtog_q;
              if (!wtog_q) begin
                low_byte_q <= WDATA;
              end
            end
            if (dat_rd && fmt_q == `FMT_LOW_HIGH) begin
              rtog_q <= !rtog_q;
            end
            if (load_done) begin
              preset_q <= wval;
              case (cfg_q)
                `CFG_TERMINAL, `CFG_SOFT_STROBE: begin
                  count_q <= wval;
                  armed_q <= 1'b1;
                  out_q <= (cfg_q == `CFG_SOFT_STROBE);
                end
                `CFG_RATE, `CFG_SQUARE: begin
                  if (!armed_q) begin
                    reload_q <= 1'b1;
                  end
                  armed_q <= 1'b1;
                end
                default: begin
                  // One-shots keep the running cycle; new count waits
                end
              endcase
            end else if (gate_rise &&
                (cfg_q == `CFG_ONE_SHOT || cfg_q == `CFG_HARD_STROBE)) begin
              count_q <= preset_q;
              armed_q <= 1'b1;
              out_q <= (cfg_q != `CFG_ONE_SHOT);
            end else if (gate_rise &&
                (cfg_q == `CFG_RATE || cfg_q == `CFG_SQUARE)) begin
              reload_q <= 1'b1;
            end else if (tick && reload_q) begin
              count_q <= preset_q;
              reload_q <= 1'b0;
              half_q <= 1'b0;
            end else if (tick) begin
              case (cfg_q)
                `CFG_TERMINAL: begin
                  if (gate_ok) begin
                    count_q <= nxt;
                    if (at_one && armed_q) begin
                      out_q <= 1'b1;
                      armed_q <= 1'b0;
                    end
                  end
                end
                `CFG_ONE_SHOT: begin
                  count_q <= nxt;
                  if (at_one && armed_q) begin
                    out_q <= 1'b1;
                    armed_q <= 1'b0;
                  end
                end
                `CFG_RATE: begin
                  if (!gate_ok) begin
                    out_q <= 1'b1;
                  end else if (armed_q) begin
                    out_q <= !at_two;
                    count_q <= at_one ? preset_q : nxt;
                  end
                end
                `CFG_SQUARE: begin
                  if (!gate_ok) begin
                    out_q <= 1'b1;
                  end else if (armed_q) begin
                    // Odd N: one extra count spent in the high half
                    if (count_q[0] && !half_q && out_q) begin
                      count_q <= nxt;
                      half_q <= 1'b1;
                    end else if (at_two || at_one) begin
                      out_q <= !out_q;
                      count_q <= out_q ? {preset_q[WIDTH-1:1], 1'b0} : preset_q;
                      half_q <= 1'b0;
                    end else begin
                      count_q <= nxt2;
                    end
                  end
                end
                `CFG_SOFT_STROBE, `CFG_HARD_STROBE: begin
                  if (gate_ok || cfg_q == `CFG_HARD_STROBE) begin
                    count_q <= nxt;
                    out_q <= !(at_one && armed_q);
                    if (at_one) begin
                      armed_q <= 1'b0;
                    end
                  end
                end
                default: begin
                  count_q <= count_q;
                end
              endcase
            end
            if (!gate_ok && (cfg_q == `CFG_RATE || cfg_q == `CFG_SQUARE)) begin
              out_q <= 1'b1;
            end
          end
        end
      end
    end
  endgenerate

  // Registered read data; unmapped and control reads return zero
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      RDATA <= 8'h00;
    end else if (CE && RD) begin
      case (port)
        3'h0, 3'h1, 3'h2: begin
          RDATA <= (rd_flip[port[1:0]] || rd_fmt_hi[port[1:0]]) ?
                   rd_val[port[1:0]][15:8] : rd_val[port[1:0]][7:0];
        end
        default: begin
          RDATA <= 8'h00;
        end
      endcase
    end
  end
endmodule // interval_timer
`default_nettype wire

// ===== bench/interval_timer_props.sv
// Port property checker for the interval timer
`timescale 1ns/100ps
`default_nettype none
module interval_timer_props #(
  parameter CHANNELS = 3,
  parameter WIDTH = 16
) (
  // System
  input wire CLOCK,
  input wire RST_N,
  input wire CE,
  // Register window
  input wire [2:0] ADDR,
  input wire WR,
  input wire RD,
  input wire [7:0] WDATA,
  input wire [7:0] RDATA,
  // Counter pins
  input wire [CHANNELS-1:0] CNT_CLK,
  input wire [CHANNELS-1:0] CNT_GATE,
  input wire [CHANNELS-1:0] CNT_OUT
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  logic [2:0] cfg1_q;
  // Tracks counter one configuration so gate rules can be scoped
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      cfg1_q <= 3'h0;
    end else if (CE && WR && ADDR == 3'h7 && WDATA[7:6] == 2'h1
                 && WDATA[5:4] != 2'h0) begin
      cfg1_q <= WDATA[3:1];
    end
  end
  AST_RST: assert property ($rose(RST_N) |-> RDATA == 8'h00
    && CNT_OUT == '0) else $error("outputs not cleared by reset");
  AST_UNMAPPED: assert property (CE && RD && !ADDR[2] |=>
    RDATA == 8'h00) else $error("unmapped read not zero");
  AST_CTL_READ: assert property (CE && RD && ADDR == 3'h7 |=>
    RDATA == 8'h00) else $error("control read not zero");
  AST_HOLD: assert property (!RD |=> $stable(RDATA))
    else $error("read data moved without a read");
  AST_QUIET: assert property (!WR && $stable(CNT_CLK)
    && $stable(CNT_GATE) |=> $stable(CNT_OUT))
    else $error("output moved without a cause");
  AST_TERM_LOW: assert property (WR && ADDR == 3'h7
    && WDATA[7:6] == 2'h0 && WDATA[5:4] != 2'h0 && WDATA[3:1] == 3'h0
    |=> !CNT_OUT[0]) else $error("terminal config output not low");
  AST_STROBE_HIGH: assert property (WR && ADDR == 3'h7
    && WDATA[7:6] == 2'h0 && WDATA[5:4] != 2'h0 && WDATA[3:1] == 3'h4
    |=> CNT_OUT[0]) else $error("strobe config output not high");
  AST_RATE_GATE: assert property (cfg1_q == 3'h2 && !CNT_GATE[1]
    && !$past(CNT_GATE[1]) |-> CNT_OUT[1])
    else $error("low gate did not force output high");
  AST_RATE_PULSE: assert property (cfg1_q == 3'h2
    && $fell(CNT_OUT[1]) |=> !CNT_OUT[1])
    else $error("rate pulse shorter than a count");
endmodule // interval_timer_props
bind interval_timer interval_timer_props #(.CHANNELS(CHANNELS),
  .WIDTH(WIDTH)) props_u (.CLOCK(CLOCK), .RST_N(RST_N), .CE(CE),
  .ADDR(ADDR), .WR(WR), .RD(RD), .WDATA(WDATA), .RDATA(RDATA),
  .CNT_CLK(CNT_CLK), .CNT_GATE(CNT_GATE), .CNT_OUT(CNT_OUT));
`default_nettype wire

// ===== bench/count_source.sv
// Count clock source standing in for the external pulse inputs
`timescale 1ns/100ps
`default_nettype none
module count_source (
  // Clock and tick request
  input wire logic clk,
  input wire logic [2:0] fire,
  // Count clocks
  output logic [2:0] cclk
);
  logic [1:0] n_q = 2'h0;
  logic [2:0] m_q = 3'h0;
  always_ff @(posedge clk) begin
    if (|fire) begin
      n_q <= 2'h2;
      m_q <= fire;
    end else if (n_q != 2'h0) begin
      n_q <= n_q - 2'h1;
    end
  end
  // Two cycles high, then low until asked again: keeps ticks spaced
  assign cclk = (n_q != 2'h0) ? m_q : 3'h0;
endmodule // count_source
`default_nettype wire

// ===== bench/test_three_channel_interval_timer.sv
// Self-checking bench for the three channel interval timer
`timescale 1ns/100ps
`default_nettype none
module test_three_channel_interval_timer;
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  logic CE = 1'b1;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [2:0] ADDR = 3'h0;
  logic [2:0] CNT_GATE = 3'h0;
  logic [2:0] fire = 3'h0;
  logic [7:0] WDATA = 8'h00;
  logic [7:0] RDATA;
  logic [7:0] b;
  logic [2:0] CNT_CLK;
  logic [2:0] CNT_OUT;
  logic [15:0] v;
  int n_mismatch = 0;
  int comparisons = 0;
  int k;
  always #5 CLOCK = ~CLOCK;
  interval_timer dut_u (.CLOCK(CLOCK), .RST_N(RST_N), .CE(CE),
    .ADDR(ADDR), .WR(WR), .RD(RD), .WDATA(WDATA), .RDATA(RDATA),
    .CNT_CLK(CNT_CLK), .CNT_GATE(CNT_GATE), .CNT_OUT(CNT_OUT));
  count_source src_u (.clk(CLOCK), .fire(fire), .cclk(CNT_CLK));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    ADDR = a;
    WDATA = d;
    WR = 1'b1;
    @(negedge CLOCK);
    WR = 1'b0;
    @(negedge CLOCK);
  endtask
  task rd(input logic [2:0] a, output logic [7:0] d);
    ADDR = a;
    RD = 1'b1;
    @(negedge CLOCK);
    RD = 1'b0;
    d = RDATA;
    @(negedge CLOCK);
  endtask
  task wr16(input logic [2:0] a, input logic [15:0] d);
    wr(a, d[7:0]);
    wr(a, d[15:8]);
  endtask
  task rd16(input logic [2:0] a, output logic [15:0] d);
    rd(a, d[7:0]);
    rd(a, d[15:8]);
  endtask
  // One count per pass; output sampled once the tick has landed
  task ticks(input int ch, input int n, output int lows);
    lows = 0;
    repeat (n) begin
      fire = 3'h1 << ch;
      @(negedge CLOCK);
      fire = 3'h0;
      repeat (4) @(negedge CLOCK);
      if (CNT_OUT[ch] === 1'b0) lows++;
    end
  endtask
  task test_done;
    $display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Whole sequence needs well under a tenth of this span
  initial begin
    #100000;
    n_mismatch++;
    test_done;
  end
  initial begin
    repeat (3) @(negedge CLOCK);
    RST_N = 1'b1;
    rd(3'h1, b);
    chk({8'h00, b}, 16'h0000);
    rd(3'h7, b);
    chk({8'h00, b}, 16'h0000);
    CNT_GATE = 3'h7;
    wr(3'h7, 8'h31);
    wr16(3'h4, 16'h0005);
    ticks(0, 4, k);
    chk(16'(CNT_OUT[0]), 16'h0000);
    ticks(0, 1, k);
    chk(16'(CNT_OUT[0]), 16'h0001);
    ticks(0, 2, k);
    CNT_GATE[0] = 1'b0;
    ticks(0, 3, k);
    CNT_GATE[0] = 1'b1;
    wr(3'h7, 8'h00);
    ticks(0, 1, k);
    rd16(3'h4, v);
    chk(v, 16'h9998);
    rd16(3'h4, v);
    chk(v, 16'h9997);
    chk(16'(CNT_OUT[0]), 16'h0001);
    wr(3'h7, 8'h74);
    wr16(3'h5, 16'h0003);
    ticks(1, 2, k);
    ticks(1, 9, k);
    chk(16'(k), 16'h0003);
    ticks(1, 1, k);
    chk(16'(CNT_OUT[1]), 16'h0000);
    // Gate drops inside the low pulse, so the force is visible
    CNT_GATE[1] = 1'b0;
    repeat (3) @(negedge CLOCK);
    chk(16'(CNT_OUT[1]), 16'h0001);
    wr(3'h7, 8'h72);
    wr16(3'h5, 16'h0003);
    CNT_GATE[1] = 1'b1;
    ticks(1, 2, k);
    chk(16'(k), 16'h0002);
    CNT_GATE[1] = 1'b0;
    @(negedge CLOCK);
    CNT_GATE[1] = 1'b1;
    ticks(1, 2, k);
    chk(16'(k), 16'h0002);
    wr16(3'h5, 16'h0005);
    ticks(1, 1, k);
    chk(16'(CNT_OUT[1]), 16'h0001);
    wr(3'h7, 8'h7a);
    wr16(3'h5, 16'h0002);
    CNT_GATE[1] = 1'b0;
    @(negedge CLOCK);
    CNT_GATE[1] = 1'b1;
    ticks(1, 1, k);
    CNT_GATE[1] = 1'b0;
    @(negedge CLOCK);
    CNT_GATE[1] = 1'b1;
    ticks(1, 1, k);
    chk(16'(k), 16'h0000);
    ticks(1, 3, k);
    chk(16'(k), 16'h0001);
    wr(3'h7, 8'hb6);
    wr16(3'h6, 16'h0005);
    ticks(2, 2, k);
    ticks(2, 10, k);
    chk(16'(k), 16'h0004);
    wr(3'h7, 8'h38);
    chk(16'(CNT_OUT[0]), 16'h0001);
    CNT_GATE[0] = 1'b0;
    wr16(3'h4, 16'h0002);
    ticks(0, 4, k);
    chk(16'(k), 16'h0000);
    CNT_GATE[0] = 1'b1;
    ticks(0, 5, k);
    chk(16'(k), 16'h0001);
    CE = 1'b0;
    ticks(0, 3, k);
    CE = 1'b1;
    rd16(3'h4, v);
    chk(v, 16'hfffd);
    test_done;
  end
endmodule // test_three_channel_interval_timer
`default_nettype wire
